// ===== hw/udtb_base_regs.sv
// The address map and strobed register access are this design's own decisions.
`include "udtb_defs.svh"

// Functional notes
// R1: low register bits 7:1 give base 15:9
// R2: low register bit 0 reads zero
// R3: mid register bits 7:0 give base 23:16
// R4: high register bits 7:0 give base 31:24
// R5: base is 512-byte aligned, bits 8:0 zero
// R6: assembled base drives table start address
// R7: register bits 31:8 read zero, ignore writes
// R8: implemented bits read/write, reset to zero
module udtb_base_regs
	import udtb_pkg::*;
#(
	parameter int ADDR_W = 8 // Register address width
) (
	// Clock and reset
	input  logic               clk,
	input  logic               rst_n,
	// Register port
	input  logic [ADDR_W-1:0]  regAddr,
	input  logic [31:0]        wrData,
	input  logic               wrStrobe,
	input  logic               rdStrobe,
	output logic [31:0]        rdData,
	// Descriptor table start for the USB engine
	output logic [31:0]        tableBase
);

	// Offsets must fit the address width
	if (ADDR_W < 4) begin : gCheck
		$error("udtb_base_regs: ADDR_W must be at least 4");
	end

	// Map an address onto a register; used by write and read paths
	function automatic udtb_sel_t decodeSel(
		input logic [ADDR_W-1:0] a
	);
		udtb_sel_t s;
		s = UDTB_SEL_NONE;
		if (a == ADDR_W'(`UDTB_OFF_LOW)) begin
			s = UDTB_SEL_LOW;
		end else if (a == ADDR_W'(`UDTB_OFF_MID)) begin
			s = UDTB_SEL_MID;
		end else if (a == ADDR_W'(`UDTB_OFF_HIGH)) begin
			s = UDTB_SEL_HIGH;
		end
		return s;
	endfunction

	// Implemented-bit mask per register index
	function automatic udtb_field_t fieldMask(input int idx);
		udtb_field_t m;
		case (idx)
			0:       m = `UDTB_MASK_LOW;
			1:       m = `UDTB_MASK_MID;
			default: m = `UDTB_MASK_HIGH;
		endcase
		return m;
	endfunction

	udtb_sel_t   wrSel;   // Register hit by a write
	udtb_sel_t   rdSel;   // Register hit by a read
	logic [31:0] rdData_q; // Read data, one cycle after strobe
	logic [31:0] rdData_d; // Next read data

	// Field links, index 0 low, 1 mid, 2 high
	udtb_field_if fldIf [`UDTB_NUM_REGS] ();

	// Same decode for writes and reads, so they never disagree
	assign wrSel = decodeSel(regAddr);
	assign rdSel = decodeSel(regAddr);

	// Field storage; one instance per register
	for (genvar i = 0; i < `UDTB_NUM_REGS; i++) begin : gFld
		// R7: only the low byte of wrData is ever offered
		assign fldIf[i].wrVal = wrData[7:0];
		// R8: write enable from the address decode
		assign fldIf[i].wrEn  = wrStrobe && (wrSel == udtb_sel_t'(i));
		// R2: mask keeps bit 0 of the low field at zero
		udtb_field #(
			.IMPL_MASK (fieldMask(i))
		) udtb_field_inst (
			.clk   (clk),
			.rst_n (rst_n),
			.fld   (fldIf[i])
		);
	end

	// Read mux; data stands only in the cycle after the strobe
	always_comb begin
		rdData_d = 32'h0000_0000;
		if (rdStrobe) begin
			// R7: upper 24 bits always zero
			case (rdSel)
				UDTB_SEL_LOW:  rdData_d = {24'h00_0000, fldIf[0].curVal};
				UDTB_SEL_MID:  rdData_d = {24'h00_0000, fldIf[1].curVal};
				UDTB_SEL_HIGH: rdData_d = {24'h00_0000, fldIf[2].curVal};
				// Unmapped addresses read as zero
				default:       rdData_d = 32'h0000_0000;
			endcase
		end
	end

	// Read data register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_q <= `UDTB_RDATA_RST;
		end else begin
			rdData_q <= rdData_d;
		end
	end

	// Port copy of the read register
	assign rdData = rdData_q;

	// R6: assembled base from the stored fields
	// R5: bits 8:0 tied to zero, table is 512-byte aligned
	// R1: low field bits 7:1 become base bits 15:9
	// R3: mid field becomes base bits 23:16
	// R4: high field becomes base bits 31:24
	// Bits 31:9 come straight from field flops and bits 8:0 are constant, so no glitch
	assign tableBase = {
		fldIf[2].curVal,
		fldIf[1].curVal,
		fldIf[0].curVal[7:1],
		`UDTB_ALIGN_ZERO
	};

	// Checks

	// One clock for every check; all off during reset
	default clocking cbClk @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	logic first_q; // High in the first cycle after reset release
	logic first_d; // Next value: low once out of reset

	// Next value of the marker
	always_comb begin
		first_d = 1'h0;
	end

	// Marks the first edge out of reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			first_q <= 1'h1;
		end else begin
			first_q <= first_d;
		end
	end

	// A write to the given register offset
	sequence s_wr_at(logic [ADDR_W-1:0] off);
		wrStrobe && (regAddr == off);
	endsequence

	// A read from the given register offset
	sequence s_rd_at(logic [ADDR_W-1:0] off);
		rdStrobe && (regAddr == off);
	endsequence

	// R1: low write lands
	property p_low_write;
		s_wr_at(ADDR_W'(`UDTB_OFF_LOW))
			|=> tableBase[15:9] == $past(wrData[7:1]);
	endproperty
	a_low_write: assert property (p_low_write) // R1
		else $error("low field write not seen on base 15:9");

	// R2: bit 0 reads zero
	property p_low_bit0;
		s_rd_at(ADDR_W'(`UDTB_OFF_LOW))
			|=> rdData[0] == 1'b0 && rdData[7:1] == tableBase[15:9];
	endproperty
	a_low_bit0: assert property (p_low_bit0) // R2
		else $error("low register bit 0 or readback wrong");

	// R3: mid write lands
	property p_mid_write;
		s_wr_at(ADDR_W'(`UDTB_OFF_MID))
			|=> tableBase[23:16] == $past(wrData[7:0])
				&& $stable(tableBase[15:0]);
	endproperty
	a_mid_write: assert property (p_mid_write) // R3
		else $error("mid field write not seen on base 23:16");

	// R4: high write lands
	property p_high_write;
		s_wr_at(ADDR_W'(`UDTB_OFF_HIGH))
			|=> tableBase[31:24] == $past(wrData[7:0])
				&& $stable(tableBase[23:0]);
	endproperty
	a_high_write: assert property (p_high_write) // R4
		else $error("high field write not seen on base 31:24");

	// R5: alignment bits zero
	property p_align;
		tableBase[8:0] == `UDTB_ALIGN_ZERO;
	endproperty
	a_align: assert property (p_align) // R5
		else $error("table base not 512-byte aligned");

	// R6: base holds between writes
	property p_hold;
		!wrStrobe |=> $stable(tableBase);
	endproperty
	a_hold: assert property (p_hold) // R6
		else $error("table base moved without a write");

	// R7: upper bits zero
	property p_upper_zero;
		rdStrobe |=> rdData[31:8] == 24'h00_0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) // R7
		else $error("register upper bits read nonzero");

	// R8: high readback
	property p_rd_high;
		s_rd_at(ADDR_W'(`UDTB_OFF_HIGH))
			|=> rdData == {24'h00_0000, tableBase[31:24]};
	endproperty
	a_rd_high: assert property (p_rd_high) // R8
		else $error("high register readback wrong");

	// R8: cleared at reset
	property p_reset_zero;
		first_q |-> tableBase == 32'h0000_0000 && rdData == 32'h0000_0000;
	endproperty
	a_reset_zero: assert property (p_reset_zero) // R8
		else $error("fields not zero after reset");

	// R7: no stray read data
	property p_idle_read;
		!rdStrobe |=> rdData == 32'h0000_0000;
	endproperty
	a_idle_read: assert property (p_idle_read) // R7
		else $error("read data present without a read strobe");

	// Write to none of the mapped offsets
	sequence s_wr_unmapped;
		wrStrobe && regAddr != ADDR_W'(`UDTB_OFF_LOW)
			&& regAddr != ADDR_W'(`UDTB_OFF_MID)
			&& regAddr != ADDR_W'(`UDTB_OFF_HIGH);
	endsequence

	// Read from none of the mapped offsets
	sequence s_rd_unmapped;
		rdStrobe && regAddr != ADDR_W'(`UDTB_OFF_LOW)
			&& regAddr != ADDR_W'(`UDTB_OFF_MID)
			&& regAddr != ADDR_W'(`UDTB_OFF_HIGH);
	endsequence

	// Write then read of one offset, no gap between
	sequence s_wr_then_rd(logic [ADDR_W-1:0] off);
		s_wr_at(off) ##1 s_rd_at(off);
	endsequence

	// A read followed by an idle cycle
	sequence s_rd_then_idle;
		rdStrobe ##1 !rdStrobe;
	endsequence

	// R6: stray write ignored
	property p_unmapped_write;
		s_wr_unmapped |=> $stable(tableBase);
	endproperty
	a_unmapped_write: assert property (p_unmapped_write) // R6
		else $error("write to an unmapped offset moved the base");

	// R7: stray read zero
	property p_rd_unmapped;
		s_rd_unmapped |=> rdData == 32'h0000_0000;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) // R7
		else $error("read of an unmapped offset returned data");

	// R3: mid readback
	property p_rd_mid;
		s_rd_at(ADDR_W'(`UDTB_OFF_MID))
			|=> rdData == {24'h00_0000, tableBase[23:16]};
	endproperty
	a_rd_mid: assert property (p_rd_mid) // R3
		else $error("mid register readback wrong");

	// R1: low write only
	property p_low_hold;
		s_wr_at(ADDR_W'(`UDTB_OFF_LOW)) |=> $stable(tableBase[31:16]);
	endproperty
	a_low_hold: assert property (p_low_hold) // R1
		else $error("low field write disturbed base 31:16");

	// R4: written byte reads back
	property p_wr_then_rd;
		s_wr_then_rd(ADDR_W'(`UDTB_OFF_HIGH))
			|=> rdData == {24'h00_0000, $past(wrData[7:0], 2)};
	endproperty
	a_wr_then_rd: assert property (p_wr_then_rd) // R4
		else $error("high register readback after write wrong");

	// R7: read data one cycle
	property p_rd_one_cycle;
		s_rd_then_idle |=> rdData == 32'h0000_0000;
	endproperty
	a_rd_one_cycle: assert property (p_rd_one_cycle) // R7
		else $error("read data stood longer than one cycle");

endmodule // udtb_base_regs

// ===== include/udtb_defs.svh
`ifndef UDTB_DEFS_SVH
`define UDTB_DEFS_SVH

// Register byte offsets on the plain register port
`define UDTB_OFF_LOW      8'h00
`define UDTB_OFF_MID      8'h04
`define UDTB_OFF_HIGH     8'h08

// Implemented bits of each 8-bit field
`define UDTB_MASK_LOW     8'hFE
`define UDTB_MASK_MID     8'hFF
`define UDTB_MASK_HIGH    8'hFF

// Reset value of every implemented field
`define UDTB_FIELD_RST    8'h00

// Reset value of the read data register
`define UDTB_RDATA_RST    32'h0000_0000

// Field positions inside the assembled table base
`define UDTB_LOW_LSB      9
`define UDTB_MID_LSB      16
`define UDTB_HIGH_LSB     24

// Alignment of the table: low address bits forced to zero
`define UDTB_ALIGN_BITS   9
`define UDTB_ALIGN_ZERO   9'h000

// Register count
`define UDTB_NUM_REGS     3

`endif

// ===== include/udtb_pkg.sv
package udtb_pkg;

	// Register selected by a bus address
	typedef enum logic [1:0] {
		UDTB_SEL_LOW  = 2'b00,
		UDTB_SEL_MID  = 2'b01,
		UDTB_SEL_HIGH = 2'b10,
		UDTB_SEL_NONE = 2'b11
	} udtb_sel_t;

	// One stored byte-wide field
	typedef logic [7:0] udtb_field_t;

endpackage

// ===== include/udtb_field_if.sv
// Link between the bus decoder and one stored field
interface udtb_field_if;
	logic                 wrEn;    // Write this field now
	udtb_pkg::udtb_field_t wrVal;  // Byte to store
	udtb_pkg::udtb_field_t curVal; // Stored value, masked

	// Field storage side
	modport store (
		input  wrEn,
		input  wrVal,
		output curVal
	);

	// Decoder side
	modport ctrl (
		output wrEn,
		output wrVal,
		input  curVal
	);
endinterface

// ===== hw/udtb_field.sv
`include "udtb_defs.svh"

// One byte-wide table-base field; unimplemented bits never store
module udtb_field
	import udtb_pkg::*;
#(
	parameter udtb_field_t IMPL_MASK = `UDTB_MASK_MID
) (
	// Clock and reset
	input  logic         clk,
	input  logic         rst_n,
	// Decoder link
	udtb_field_if.store  fld
);

	udtb_field_t val_q; // Stored field
	udtb_field_t val_d; // Next value

	// Next value: masked write, else hold
	always_comb begin
		val_d = val_q;
		if (fld.wrEn) begin
			val_d = fld.wrVal & IMPL_MASK;
		end
	end

	// Storage, cleared at power-on reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			val_q <= `UDTB_FIELD_RST;
		end else begin
			val_q <= val_d;
		end
	end

	assign fld.curVal = val_q;

endmodule // udtb_field

// ===== dv/test_udtb_base_regs.sv
`include "udtb_defs.svh"

module test_udtb_base_regs;
	timeunit 1ns;
	timeprecision 1ps;

	// One table row: address, write word, expected readback
	typedef struct {
		logic [7:0]  addr;
		logic [31:0] data;
		logic [31:0] rdExp;
	} udtb_row_t;

	// Design stimulus and results
	logic        clk             = 1'b0;
	logic        rst_n           = 1'b0;
	logic [7:0]  regAddr         = 8'h00;
	logic [31:0] wrData          = 32'h0;
	logic        wrStrobe        = 1'b0;
	logic        rdStrobe        = 1'b0;
	logic [31:0] rdData;
	logic [31:0] tableBase;
	// Bench copy of the three fields
	logic [7:0]  loM             = 8'h00;
	logic [7:0]  midM            = 8'h00;
	logic [7:0]  hiM             = 8'h00;
	int          error_cnt       = 0;
	int          samples_checked = 0;
	udtb_row_t   rows [6];

	// 8 ns clock
	always #4 clk = ~clk;

	udtb_base_regs #(.ADDR_W(8)) udtb_base_regs_inst (
		.clk       (clk),
		.rst_n     (rst_n),
		.regAddr   (regAddr),
		.wrData    (wrData),
		.wrStrobe  (wrStrobe),
		.rdStrobe  (rdStrobe),
		.rdData    (rdData),
		.tableBase (tableBase)
	);

	// Compare one 32-bit result; x never matches
	task automatic check(input string n, input logic [31:0] e,
			input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic finish_test();
		$display("Checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Single-cycle write strobe
	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wrStrobe <= 1'b1;
		regAddr  <= a;
		wrData   <= d;
		@(posedge clk);
		wrStrobe <= 1'b0;
		// Unmapped offsets change nothing
		case (a)
			`UDTB_OFF_LOW:  loM = d[7:0] & 8'hFE;
			`UDTB_OFF_MID:  midM = d[7:0];
			`UDTB_OFF_HIGH: hiM = d[7:0];
			default: ;
		endcase
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		rdStrobe <= 1'b1;
		regAddr  <= a;
		@(posedge clk);
		rdStrobe <= 1'b0;
		#1;
		d = rdData;
	endtask

	// Hang guard, far beyond the expected run
	initial begin
		repeat (3000) @(posedge clk);
		error_cnt++;
		finish_test();
	end

	initial begin
		logic [31:0] v;
		rows = '{'{8'h00, 32'hFFFFFFFF, 32'h000000FE},
			'{8'h04, 32'h123456AB, 32'h000000AB},
			'{8'h08, 32'hA5A5A5C3, 32'h000000C3},
			'{8'h00, 32'h00000057, 32'h00000056},
			'{8'h0C, 32'hFFFFFFFF, 32'h00000000},
			'{8'h04, 32'hFFFFFF81, 32'h00000081}};
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		// Power-on values of all three registers
		for (int i = 0; i < 3; i++) begin
			bus_read(8'(4 * i), v);
			check("reset read", 32'h0, v);
		end
		check("reset base", 32'h0, tableBase);
		// Ordinary cases from the table
		foreach (rows[i]) begin
			bus_write(rows[i].addr, rows[i].data);
			bus_read(rows[i].addr, v);
			check("readback", rows[i].rdExp, v);
			check("base", {hiM, midM, loM[7:1], 9'h000}, tableBase);
		end
		// Read data drop back in the following cycle
		@(posedge clk);
		#1;
		check("idle rdData", 32'h0, rdData);
		// Write then read with no gap
		@(posedge clk);
		wrStrobe <= 1'b1;
		regAddr  <= `UDTB_OFF_HIGH;
		wrData   <= 32'h0000003C;
		@(posedge clk);
		wrStrobe <= 1'b0;
		rdStrobe <= 1'b1;
		@(posedge clk);
		rdStrobe <= 1'b0;
		#1;
		check("b2b read", 32'h0000003C, rdData);
		check("b2b base", {8'h3C, midM, loM[7:1], 9'h000}, tableBase);
		// Reset in mid-run clears every field
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		check("mid reset base", 32'h0, tableBase);
		@(posedge clk);
		rst_n <= 1'b1;
		// Every register reads its power-on value again
		for (int i = 0; i < 3; i++) begin
			bus_read(8'(4 * i), v);
			check("mid reset read", 32'h0, v);
		end
		finish_test();
	end

endmodule // test_udtb_base_regs
